// >>> shared/ixe_pkg.sv
/*
 Shared constants and types for the byte-instruction execute slice:
 opcode patterns, addressing limits, register offsets, field positions,
 reset values, phase and operation enums, and the data memory carrier.
 Assumes an 8-bit data path, 12-bit data addresses and 32-bit APB data.
*/
package ixe_pkg;

   // widths of the data path
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned BANK_W = 4;

   // opcode patterns in the upper bits of the instruction word
   localparam logic [5:0] OPC_INC_SKIP = 6'h12;  // 0100 10da
   localparam logic [5:0] OPC_OR_FILE  = 6'h04;  // 0001 00da
   localparam logic [7:0] OPC_OR_LIT   = 8'h09;  // 0000 1001

   // instruction word fields
   localparam int unsigned DEST_BIT = 9;
   localparam int unsigned BANK_BIT = 8;

   // addressing limits
   localparam logic [7:0] INDEXED_MAX      = 8'h5F;
   localparam logic [7:0] ACCESS_SPLIT_DEF = 8'h80;
   localparam logic [3:0] ACCESS_LOW_BANK  = 4'h0;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

   // discarded instruction cycles after a skip
   localparam logic [1:0] NOP_SINGLE = 2'h1;
   localparam logic [1:0] NOP_DOUBLE = 2'h2;

   // register byte offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_BANK   = 8'h04;
   localparam logic [7:0] REG_ACC    = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_INDEX  = 8'h10;
   localparam logic [7:0] REG_SKIPS  = 8'h14;

   // field positions
   localparam int unsigned CTRL_EXT_BIT = 0;
   localparam int unsigned STAT_Z_BIT   = 0;
   localparam int unsigned STAT_N_BIT   = 1;
   localparam int unsigned STAT_NOP_BIT = 2;

   // reset values
   localparam logic [7:0]  RST_ACC   = 8'h00;
   localparam logic [3:0]  RST_BANK  = 4'h0;
   localparam logic [11:0] RST_INDEX = 12'h000;
   localparam logic        RST_EXT   = 1'b0;

   typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} ixe_phase_t;

   typedef enum logic [2:0] {OP_NONE, OP_INC, OP_ORL, OP_ORF, OP_BAD}
      ixe_op_t;

   typedef struct packed {
      logic              re;
      logic              we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } ixe_mem_req_t;

endpackage

// >>> rtl/ixe_exec.sv
/*
 Execute slice for increment-and-skip-unless-null and the two OR forms.
 Runs four phase ticks of ref_clk per instruction cycle. Assumes the
 fetch unit holds instr_word while instr_valid is high and the banked
 data memory returns read data combinationally from mem_req.addr.
*/
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/10ps

module ixe_exec
   import ixe_pkg::*;
#(
   parameter logic [7:0] ACCESS_SPLIT = ACCESS_SPLIT_DEF
) (
   // clock, reset, enable
   input  wire logic                ref_clk,
   input  wire logic                rst,
   input  wire logic                ce,
   // instruction fetch and data memory side
   input  wire logic                instr_valid,
   input  wire logic [15:0]         instr_word,
   input  wire logic                next_two_word,
   output ixe_pkg::ixe_mem_req_t    mem_req,
   input  wire logic [DATA_W-1:0]   mem_rdata,
   output logic                     instr_take,
   output logic                     skip_flush,
   output logic                     skip_nop,
   output logic                     illegal_op,
   // apb slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr
);

   ixe_phase_t          q,          next_q;
   ixe_op_t             op,         next_op;
   ixe_op_t             dec_op;
   ixe_mem_req_t        next_mem;
   logic [15:0]         ir,         next_ir;
   logic [1:0]          nop_left,   next_nop_left;
   logic                next_skip_nop;
   logic [DATA_W-1:0]   acc,        next_acc;
   logic [DATA_W-1:0]   result,     next_result;
   logic [BANK_W-1:0]   bank,       next_bank;
   logic [ADDR_W-1:0]   index_base, next_index_base;
   logic                ext_en,     next_ext_en;
   logic                flag_n,     next_flag_n;
   logic                flag_z,     next_flag_z;
   logic [7:0]          skip_cnt,   next_skip_cnt;
   logic                next_instr_take;
   logic                next_skip_flush;
   logic                next_illegal;
   logic [31:0]         next_prdata;
   logic                next_pslverr;
   logic                file_op;

   // opcode decode; anything outside the three patterns runs as a no-op
   function automatic ixe_op_t decode_op(input logic [15:0] w);
      if (w[15:10] == OPC_INC_SKIP) return OP_INC;
      if (w[15:8] == OPC_OR_LIT) return OP_ORL;
      if (w[15:10] == OPC_OR_FILE) return OP_ORF;
      return OP_BAD;
   endfunction

   // data address from bank bit and register field
   function automatic logic [ADDR_W-1:0] file_addr(input logic a,
                                                    input logic [7:0] f);
      if (a) return {bank, f};
      if (ext_en && f <= INDEXED_MAX)
         return ADDR_W'(index_base + {4'h0, f});
      if (f < ACCESS_SPLIT) return {ACCESS_LOW_BANK, f};
      return {ACCESS_HIGH_BANK, f};
   endfunction

   // register read mux; unmapped offsets read zero and flag an error
   function automatic logic [32:0] reg_read(input logic [7:0] a);
      case (a)
         REG_CTRL:   return {1'b0, 31'h0, ext_en};
         REG_BANK:   return {1'b0, 28'h0, bank};
         REG_ACC:    return {1'b0, 24'h0, acc};
         REG_STATUS: return {1'b0, 29'h0, skip_nop, flag_n, flag_z};
         REG_INDEX:  return {1'b0, 20'h0, index_base};
         REG_SKIPS:  return {1'b0, 24'h0, skip_cnt};
         default:    return {1'b1, 32'h0};
      endcase
   endfunction

   assign dec_op  = decode_op(instr_word);
   assign file_op = (op == OP_INC) || (op == OP_ORF);

   // next state: apb slave first, then the phase sequencer, so an
   // execute write to the accumulator wins over a same-cycle bus write
   always_comb begin
      next_q          = q;
      next_op         = op;
      next_ir         = ir;
      next_nop_left   = nop_left;
      next_skip_nop   = skip_nop;
      next_acc        = acc;
      next_result     = result;
      next_bank       = bank;
      next_index_base = index_base;
      next_ext_en     = ext_en;
      next_flag_n     = flag_n;
      next_flag_z     = flag_z;
      next_skip_cnt   = skip_cnt;
      next_instr_take = 1'b0;
      next_skip_flush = 1'b0;
      next_illegal    = 1'b0;
      next_mem        = mem_req;
      next_mem.re     = 1'b0;
      next_mem.we     = 1'b0;
      next_prdata     = prdata;
      next_pslverr    = pslverr;
      // setup phase latches the answer so the access phase ends at once
      if (psel && !penable) begin
         {next_pslverr, next_prdata} = reg_read(paddr);
      end
      if (psel && penable && pready && pwrite) begin
         case (paddr)
            REG_CTRL:  next_ext_en     = pwdata[CTRL_EXT_BIT];
            REG_BANK:  next_bank       = pwdata[BANK_W-1:0];
            REG_ACC:   next_acc        = pwdata[DATA_W-1:0];
            REG_INDEX: next_index_base = pwdata[ADDR_W-1:0];
            REG_SKIPS: next_skip_cnt   = 8'h00;  // write clears the count
            default:   ;
         endcase
      end
      unique case (q)
         PH_Q1: begin
            next_q        = PH_Q2;
            next_skip_nop = (nop_left != 2'h0);
            if (nop_left != 2'h0) begin
               // discarded word: the whole cycle does nothing
               next_nop_left = nop_left - 2'h1;
               next_op       = OP_NONE;
            end else if (instr_valid) begin
               next_ir         = instr_word;
               next_op         = dec_op;
               next_instr_take = 1'b1;
               next_illegal    = (dec_op == OP_BAD);
            end else begin
               next_op = OP_NONE;
            end
         end
         PH_Q2: begin
            next_q = PH_Q3;
            if (file_op) begin
               next_mem.re   = 1'b1;
               next_mem.addr = file_addr(ir[BANK_BIT], ir[7:0]);
            end
         end
         PH_Q3: begin
            next_q = PH_Q4;
            if (op == OP_INC) begin
               next_result = mem_rdata + 8'h01;
            end else if (op == OP_ORF) begin
               next_result = acc | mem_rdata;
            end else if (op == OP_ORL) begin
               next_result = acc | ir[7:0];
            end
         end
         PH_Q4: begin
            next_q = PH_Q1;
            if (file_op && ir[DEST_BIT]) begin
               next_mem.we    = 1'b1;
               next_mem.wdata = result;
            end else if (file_op || op == OP_ORL) begin
               next_acc = result;
            end
            if (op == OP_ORL || op == OP_ORF) begin
               next_flag_n = result[DATA_W-1];
               next_flag_z = (result == 8'h00);
            end
            if (op == OP_INC && result != 8'h00) begin
               // fetch drops its word; a two-word follower costs two
               next_skip_flush = 1'b1;
               next_nop_left   = next_two_word ? NOP_DOUBLE
                                               : NOP_SINGLE;
               next_skip_cnt   = skip_cnt + 8'h01;
            end
         end
      endcase
   end

   // state registers; ce low freezes everything
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         q          <= PH_Q1;
         op         <= OP_NONE;
         ir         <= 16'h0000;
         nop_left   <= 2'h0;
         skip_nop   <= 1'b0;
         acc        <= RST_ACC;
         result     <= 8'h00;
         bank       <= RST_BANK;
         index_base <= RST_INDEX;
         ext_en     <= RST_EXT;
         flag_n     <= 1'b0;
         flag_z     <= 1'b0;
         skip_cnt   <= 8'h00;
         instr_take <= 1'b0;
         skip_flush <= 1'b0;
         illegal_op <= 1'b0;
         mem_req    <= '0;
         prdata     <= 32'h0000_0000;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
      end else if (ce) begin
         q          <= next_q;
         op         <= next_op;
         ir         <= next_ir;
         nop_left   <= next_nop_left;
         skip_nop   <= next_skip_nop;
         acc        <= next_acc;
         result     <= next_result;
         bank       <= next_bank;
         index_base <= next_index_base;
         ext_en     <= next_ext_en;
         flag_n     <= next_flag_n;
         flag_z     <= next_flag_z;
         skip_cnt   <= next_skip_cnt;
         instr_take <= next_instr_take;
         skip_flush <= next_skip_flush;
         illegal_op <= next_illegal;
         mem_req    <= next_mem;
         prdata     <= next_prdata;
         pready     <= 1'b1;  // zero-wait slave once out of reset
         pslverr    <= next_pslverr;
      end
   end

   // checks; a stalled enable voids any sequence in flight
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst || !ce);
   sequence s_nop_one;
      skip_nop [*4] ##1 !skip_nop;
   endsequence
   sequence s_nop_two;
      skip_nop [*8] ##1 !skip_nop;
   endsequence

   property p_decode_inc;
      q == PH_Q1 && nop_left == 2'h0 && instr_valid &&
      instr_word[15:10] == 6'h12 |=> op == OP_INC && instr_take;
   endproperty
   a_decode_inc: assert property (p_decode_inc)
      else $error("increment-skip pattern not decoded");

   property p_skip_nonzero;
      q == PH_Q4 && op == OP_INC && result != 8'h00
      |=> skip_flush && nop_left != 2'h0;
   endproperty
   a_skip_nonzero: assert property (p_skip_nonzero)
      else $error("nonzero increment did not skip");

   property p_skip_single;
      skip_flush && nop_left == 2'h1 |=> s_nop_one;
   endproperty
   a_skip_single: assert property (p_skip_single)
      else $error("single skip not one no-op cycle");

   property p_skip_double;
      skip_flush && nop_left == 2'h2 |=> s_nop_two;
   endproperty
   a_skip_double: assert property (p_skip_double)
      else $error("two-word skip not two no-op cycles");

   property p_no_skip;
      q == PH_Q4 && op == OP_INC && result == 8'h00
      |=> !skip_flush ##1 !skip_nop;
   endproperty
   a_no_skip: assert property (p_no_skip)
      else $error("zero result skipped");

   property p_dest_file;
      q == PH_Q4 && file_op && ir[9]
      |=> mem_req.we && mem_req.wdata == $past(result)
          && acc == $past(acc);
   endproperty
   a_dest_file: assert property (p_dest_file)
      else $error("register destination not written");

   property p_bank_sel;
      q == PH_Q2 && file_op && ir[8]
      |=> mem_req.re && mem_req.addr == {$past(bank), $past(ir[7:0])};
   endproperty
   a_bank_sel: assert property (p_bank_sel)
      else $error("banked address wrong");

   property p_indexed;
      q == PH_Q2 && file_op && !ir[8] && ext_en && ir[7:0] <= 8'h5F
      |=> mem_req.addr == $past(index_base) + {4'h0, $past(ir[7:0])};
   endproperty
   a_indexed: assert property (p_indexed)
      else $error("indexed offset address wrong");

   property p_or_lit;
      q == PH_Q3 && op == OP_ORL
      |=> result == ($past(acc) | $past(ir[7:0])) ##1
          acc == $past(result) && !mem_req.we;
   endproperty
   a_or_lit: assert property (p_or_lit)
      else $error("literal OR result wrong");

   property p_or_file;
      q == PH_Q3 && op == OP_ORF |=> result == ($past(acc) | $past(mem_rdata));
   endproperty
   a_or_file: assert property (p_or_file)
      else $error("register OR result wrong");

   property p_or_flags;
      q == PH_Q4 && (op == OP_ORL || op == OP_ORF)
      |=> flag_n == $past(result[7]) && flag_z == ($past(result) == 8'h00);
   endproperty
   a_or_flags: assert property (p_or_flags)
      else $error("OR flags wrong");

   property p_inc_flags;
      q == PH_Q4 && op == OP_INC
      |=> $stable(flag_n) && $stable(flag_z);
   endproperty
   a_inc_flags: assert property (p_inc_flags)
      else $error("increment changed flags");
endmodule

// >>> tb/ixe_mem_model.sv
/*
 Behavioural banked data memory standing on the far side of the execute
 slice. Assumes the slice drives one read or write strobe per access and
 expects read data combinationally while the read strobe is high.
*/
`timescale 1ns/10ps

module ixe_mem_model
   import ixe_pkg::*;
(
   // clock
   input  wire logic              ref_clk,
   // request and answer
   input  wire ixe_mem_req_t      mem_req,
   output logic [DATA_W-1:0]      mem_rdata
);
   logic [DATA_W-1:0] mem [0:4095];

   // clear the array so preloads start from a known state
   initial begin
      for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
   end

   // writes land on the strobe edge, as a real array would take them
   always @(posedge ref_clk) begin
      if (mem_req.we) mem[mem_req.addr] <= mem_req.wdata;
   end

   // outside a read the data is inverted, so a late sample cannot pass
   assign mem_rdata = mem_req.re ? mem[mem_req.addr] : ~mem[mem_req.addr];
endmodule

// >>> tb/tb_top.sv
/*
 Self-checking bench for the byte-instruction execute slice.
 Assumes zero-wait APB answers are still awaited by pready and that the
 slice takes a word only at the edge that ends its first phase tick.
*/
`timescale 1ns/10ps

module tb_top
   import ixe_pkg::*;
;
   logic ref_clk = 0, rst = 1, ce = 1;
   logic instr_valid = 0, next_two_word = 0;
   logic [15:0] instr_word = 16'h0000;
   logic psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, instr_take, skip_flush, skip_nop, illegal_op;
   ixe_mem_req_t mem_req;
   logic [7:0] mem_rdata;
   int failures = 0, n_checks = 0;
   int n_nop, n_flush, n_we, n_ill;
   logic [11:0] re_addr, we_addr;
   logic [7:0] we_data;
   logic [31:0] rd;
   logic err;

   ixe_exec u_dut (.ref_clk(ref_clk), .rst(rst), .ce(ce),
      .instr_valid(instr_valid), .instr_word(instr_word),
      .next_two_word(next_two_word), .mem_req(mem_req),
      .mem_rdata(mem_rdata), .instr_take(instr_take),
      .skip_flush(skip_flush), .skip_nop(skip_nop),
      .illegal_op(illegal_op), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   ixe_mem_model u_mem (.ref_clk(ref_clk), .mem_req(mem_req),
      .mem_rdata(mem_rdata));

   // 50 ns period
   always #25 ref_clk = ~ref_clk;

   // the falling edge sees every one-cycle pulse once, free of races
   always @(negedge ref_clk) begin
      if (skip_nop === 1'b1) n_nop++;
      if (skip_flush === 1'b1) n_flush++;
      if (illegal_op === 1'b1) n_ill++;
      if (mem_req.re === 1'b1) re_addr = mem_req.addr;
      if (mem_req.we === 1'b1) begin
         n_we++;
         we_addr = mem_req.addr;
         we_data = mem_req.wdata;
      end
   end

   task automatic chk(input string nm, input logic [31:0] e, g);
      n_checks++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         failures++;
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int i;
      @(posedge ref_clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      for (i = 0; i < 20; i++) begin
         @(posedge ref_clk);
         if (pready === 1'b1) break;
      end
      if (i == 20) chk("pready", 1, 0);
      rd = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a,
                         input logic [31:0] e);
      apb(0, a, 32'h0);
      chk(nm, e, rd);
      chk("pslverr", 0, err);
   endtask

   // offer a word, hold it until taken, then let the effects settle
   task automatic run(input logic [15:0] w, input logic two);
      int i;
      n_nop = 0; n_flush = 0; n_we = 0; n_ill = 0;
      re_addr = 12'hXXX;
      @(posedge ref_clk);
      instr_word <= w; instr_valid <= 1; next_two_word <= two;
      for (i = 0; i < 40; i++) begin
         @(negedge ref_clk);
         if (instr_take === 1'b1) break;
      end
      if (i == 40) chk("instr_take", 1, 0);
      @(posedge ref_clk);
      instr_valid <= 0; instr_word <= ~w;
      repeat (16) @(posedge ref_clk);
      next_two_word <= 0;
   endtask

   task automatic t_regs;
      for (int i = 0; i < 6; i++) rd_chk("reset reg", 8'(i * 4), 32'h0);
      apb(1, REG_BANK, 32'hFFFF_FFFF);
      rd_chk("bank width", REG_BANK, 32'h0000_000F);
      apb(0, 8'h40, 32'h0);
      chk("unmapped err", 1, err);
      chk("unmapped data", 0, rd);
   endtask

   task automatic t_inc_skip;
      apb(1, REG_BANK, 32'h3);
      u_mem.mem[12'h320] = 8'h41;
      run({OPC_INC_SKIP, 1'b1, 1'b1, 8'h20}, 0);
      chk("inc read addr", 12'h320, re_addr);
      chk("inc write data", 8'h42, we_data);
      chk("inc flush", 1, n_flush);
      chk("inc nop cycles", 4, n_nop);
      rd_chk("inc flags", REG_STATUS, 32'h0);
   endtask

   task automatic t_inc_zero;
      apb(1, REG_ACC, 32'h0);
      run({OPC_OR_LIT, 8'h80}, 0);
      u_mem.mem[12'h355] = 8'hFF;
      run({OPC_INC_SKIP, 1'b0, 1'b1, 8'h55}, 0);
      chk("zero flush", 0, n_flush);
      chk("zero nop", 0, n_nop);
      chk("zero no write", 0, n_we);
      rd_chk("zero acc", REG_ACC, 32'h0);
      rd_chk("zero flags", REG_STATUS, 32'h2);
   endtask

   task automatic t_access;
      u_mem.mem[12'hF90] = 8'h07;
      run({OPC_INC_SKIP, 1'b1, 1'b0, 8'h90}, 1);
      chk("high access", 12'hF90, we_addr);
      chk("two word nop", 8, n_nop);
      run({OPC_INC_SKIP, 1'b0, 1'b0, 8'h10}, 0);
      chk("low access", 12'h010, re_addr);
      rd_chk("low acc", REG_ACC, 32'h1);
   endtask

   task automatic t_indexed;
      apb(1, REG_CTRL, 32'h1);
      apb(1, REG_INDEX, 32'h200);
      u_mem.mem[12'h25F] = 8'h20;
      run({OPC_OR_FILE, 1'b0, 1'b0, 8'h5F}, 0);
      chk("indexed addr", 12'h25F, re_addr);
      rd_chk("indexed acc", REG_ACC, 32'h21);
      run({OPC_OR_FILE, 1'b0, 1'b0, 8'h60}, 0);
      chk("above index", 12'h060, re_addr);
      run({OPC_OR_FILE, 1'b0, 1'b1, 8'h05}, 0);
      chk("banked ext", 12'h305, re_addr);
      apb(1, REG_CTRL, 32'h0);
   endtask

   task automatic t_or;
      apb(1, REG_ACC, 32'h9A);
      run({OPC_OR_LIT, 8'h35}, 0);
      rd_chk("orl acc", REG_ACC, 32'hBF);
      rd_chk("orl n", REG_STATUS, 32'h2);
      chk("orl no write", 0, n_we);
      apb(1, REG_ACC, 32'h0);
      run({OPC_OR_LIT, 8'h00}, 0);
      rd_chk("orl z", REG_STATUS, 32'h1);
      apb(1, REG_ACC, 32'h40);
      u_mem.mem[12'h3F0] = 8'h13;
      run({OPC_OR_FILE, 1'b1, 1'b1, 8'hF0}, 0);
      chk("orf write", 8'h53, we_data);
      chk("orf nop", 0, n_nop);
      rd_chk("orf acc kept", REG_ACC, 32'h40);
      rd_chk("orf flags", REG_STATUS, 32'h0);
      run(16'hFFFF, 0);
      chk("illegal pulse", 1, n_ill);
   endtask

   // one single skip and two in the access scenario; any write clears
   task automatic t_count;
      rd_chk("skip count", REG_SKIPS, 32'h3);
      apb(1, REG_SKIPS, 32'hA5);
      rd_chk("skip clear", REG_SKIPS, 32'h0);
   endtask

   // a bus write while ce is low must not land: all state is frozen
   task automatic t_freeze;
      @(posedge ref_clk);
      ce <= 0;
      apb(1, REG_ACC, 32'h55);
      @(posedge ref_clk);
      ce <= 1;
      rd_chk("frozen acc", REG_ACC, 32'h40);
   endtask

   task automatic tally_and_finish;
      if (failures == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // the whole run needs a few hundred cycles; 20000 is ample margin
   initial begin
      #(50 * 20000);
      failures++;
      tally_and_finish();
   end

   initial begin
      repeat (12) @(posedge ref_clk);
      rst <= 0;
      t_regs();
      t_inc_skip();
      t_inc_zero();
      t_access();
      t_indexed();
      t_or();
      t_count();
      t_freeze();
      tally_and_finish();
   end
endmodule
